// *** shared/gtl_pkg.sv ***
// Package for the G.703 timing and loopback control block.
// Assumes one 10 MHz core clock; line bit rate is 64 kbit/s.
package gtl_pkg;
  localparam int CORE_CLK_HZ = 10000000;
  localparam int LINE_BIT_HZ = 64000;
  localparam int OCTET_HZ = 8000;
  localparam int BITS_PER_OCTET = LINE_BIT_HZ / OCTET_HZ;
  // Bit rate enable: rounded down, line period is 156.25 cycles
  localparam int BIT_DIV = CORE_CLK_HZ / LINE_BIT_HZ;
  localparam int MARK_BIT_POS = BITS_PER_OCTET - 1;
  // Reset values, as delivered
  localparam logic OCTET_EN_RESET = 1'h1;
  typedef enum logic [1:0] {
    GTL_LOOP_TIMING,
    GTL_INTERNAL_TIMING,
    GTL_MIN_REMOTE_LOOP,
    GTL_DUAL_LOOP
  } gtl_mode_t;
endpackage : gtl_pkg

// *** shared/gtl_tick_if.sv ***
// Interface carrying a bit-rate tick and its octet position.
// Assumes a single clock domain.
`timescale 1ns/1ns
interface gtl_tick_if;
  logic tick;
  logic [2:0] bit_pos;
  modport src (output tick, output bit_pos);
  modport dst (input tick, input bit_pos);
endinterface : gtl_tick_if

// *** hw/gtl_bit_timer.sv ***
// Internal bit-rate timer: one-cycle tick at the line bit rate.
// Assumes core_clk at the package rate.
`timescale 1ns/1ns
module gtl_bit_timer #(
  parameter int DIV = gtl_pkg::BIT_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic tick
);
  // The counter is 16 bits wide, so longer periods cannot be served
  if (DIV < 2 || DIV > 65536) begin : g_div_check
    $error("gtl_bit_timer: DIV out of range");
  end
  logic [15:0] cnt_q, cnt_d;
  always_comb begin
    if (cnt_q == 16'(DIV - 1)) cnt_d = 16'h0;
    else cnt_d = cnt_q + 16'h1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) cnt_q <= 16'h0;
    else cnt_q <= cnt_d;
  end
  assign tick = (cnt_q == 16'(DIV - 1));
endmodule : gtl_bit_timer

// *** hw/gtl_octet_counter.sv ***
// Octet position counter driven by the selected transmit bit tick.
// Assumes the tick is a one-cycle pulse on core_clk.
`timescale 1ns/1ns
module gtl_octet_counter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick_in,
  gtl_tick_if.src tk
);
  logic [2:0] pos_q, pos_d;
  always_comb begin
    pos_d = pos_q;
    if (tick_in) pos_d = pos_q + 3'h1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) pos_q <= 3'h0;
    else pos_q <= pos_d;
  end
  assign tk.tick = tick_in;
  assign tk.bit_pos = pos_q;
endmodule : gtl_octet_counter

// *** hw/gtl_timing_loopback.sv ***
// Timing source, octet marker and loopback steering for one G.703 channel.
// Assumes line data and recovered line timing arrive synchronous to core_clk,
// with bit strobes as one-cycle pulses; line coding is done elsewhere.
`timescale 1ns/1ns
// How it works
// - Octet marker on LSB when octet timing on, in loop and internal timing only
// - Two selects decode into four timing modes
// - Internal mode uses the internal bit timer
// - Loop mode takes recovered line timing
// - Reset state: octet on, loop timing
// - Remote loopback relatches line data to transmitter
// - Remote loopback drops internal-side transmit data
// - Line receive keeps feeding internal side in all modes but dual loopback
// - Remote loopback returns line timing unchanged
// - Dual loopback returns internal data inward
// - Dual loopback returns line data outward
// - Each loop keeps its own clock
module gtl_timing_loopback #(
  parameter int BIT_DIV = gtl_pkg::BIT_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic octet_timing_select,
  input wire logic timing_mode_select_low,
  input wire logic timing_mode_select_high,
  input wire logic cfg_load,
  input wire logic line_rx_data,
  input wire logic line_rx_tick,
  input wire logic line_rx_invert,
  input wire logic dm_rx_data,
  input wire logic dm_rx_tick,
  input wire logic dm_tx_src_data,
  output logic line_tx_data,
  output logic line_tx_tick,
  output logic line_tx_octet_mark,
  output logic dm_tx_data,
  output logic dm_tx_tick,
  output logic [1:0] mode_state
);
  if (BIT_DIV < 2 || BIT_DIV > 65536) begin : g_div_check
    $error("gtl_timing_loopback: BIT_DIV out of range");
  end

  gtl_pkg::gtl_mode_t mode_q, mode_d;
  logic octet_en_q, octet_en_d;
  logic int_tick;
  logic sel_tick;
  logic latch_q, latch_d;
  logic tx_q, tx_d;
  logic mark_q, mark_d;
  logic dmtx_q, dmtx_d;
  gtl_tick_if tk ();

  // Settings are static straps, sampled only on a clocked load after reset
  always_comb begin
    mode_d = mode_q;
    octet_en_d = octet_en_q;
    if (cfg_load) begin
      octet_en_d = octet_timing_select;
      case ({timing_mode_select_high, timing_mode_select_low})
        2'h0: mode_d = gtl_pkg::GTL_LOOP_TIMING;
        2'h1: mode_d = gtl_pkg::GTL_INTERNAL_TIMING;
        2'h2: mode_d = gtl_pkg::GTL_MIN_REMOTE_LOOP;
        default: mode_d = gtl_pkg::GTL_DUAL_LOOP;
      endcase
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= gtl_pkg::GTL_LOOP_TIMING;
      octet_en_q <= gtl_pkg::OCTET_EN_RESET;
    end else begin
      mode_q <= mode_d;
      octet_en_q <= octet_en_d;
    end
  end

  gtl_bit_timer #(.DIV(BIT_DIV)) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .tick(int_tick)
  );

  // Only internal timing runs from the local timer; every other mode follows the line
  always_comb begin
    case (mode_q)
      gtl_pkg::GTL_INTERNAL_TIMING: sel_tick = int_tick;
      default: sel_tick = line_rx_tick;
    endcase
  end

  gtl_octet_counter u_octet (
    .core_clk(core_clk),
    .rst(rst),
    .tick_in(sel_tick),
    .tk(tk)
  );

  // Stabilising latch also restores polarity of the received line bit
  always_comb begin
    latch_d = latch_q;
    if (line_rx_tick) latch_d = line_rx_data ^ line_rx_invert;
  end

  always_comb begin
    tx_d = tx_q;
    mark_d = mark_q;
    if (tk.tick) begin
      case (mode_q)
        gtl_pkg::GTL_MIN_REMOTE_LOOP, gtl_pkg::GTL_DUAL_LOOP:
          tx_d = latch_d;
        default: tx_d = dm_tx_src_data;
      endcase
      // Marker only in normal traffic; looped data goes back untouched
      mark_d = octet_en_q && (tk.bit_pos == 3'(gtl_pkg::MARK_BIT_POS))
        && (mode_q == gtl_pkg::GTL_LOOP_TIMING
        || mode_q == gtl_pkg::GTL_INTERNAL_TIMING);
    end
  end

  always_comb begin
    dmtx_d = dmtx_q;
    if (mode_q == gtl_pkg::GTL_DUAL_LOOP) begin
      if (dm_rx_tick) dmtx_d = dm_rx_data;
    end else if (line_rx_tick) begin
      dmtx_d = latch_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latch_q <= 1'h0;
      tx_q <= 1'h0;
      mark_q <= 1'h0;
      dmtx_q <= 1'h0;
    end else begin
      latch_q <= latch_d;
      tx_q <= tx_d;
      mark_q <= mark_d;
      dmtx_q <= dmtx_d;
    end
  end

  logic txt_q, dmt_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txt_q <= 1'h0;
      dmt_q <= 1'h0;
    end else begin
      txt_q <= tk.tick;
      dmt_q <= (mode_q == gtl_pkg::GTL_DUAL_LOOP) ? dm_rx_tick : line_rx_tick;
    end
  end

  assign line_tx_data = tx_q;
  assign line_tx_tick = txt_q;
  assign line_tx_octet_mark = mark_q;
  assign dm_tx_data = dmtx_q;
  assign dm_tx_tick = dmt_q;
  assign mode_state = mode_q;
endmodule : gtl_timing_loopback

// *** dv/gtl_timing_loopback_props.sv ***
// Checker for timing source, marker and loopback relations at the ports.
// Assumes BIT_DIV of at least 3 in the bound instance.
`timescale 1ns/1ns
module gtl_timing_loopback_props #(
  parameter int BIT_DIV = 156
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic octet_timing_select,
  input wire logic timing_mode_select_low,
  input wire logic timing_mode_select_high,
  input wire logic cfg_load,
  input wire logic line_rx_data,
  input wire logic line_rx_tick,
  input wire logic line_rx_invert,
  input wire logic dm_rx_data,
  input wire logic dm_rx_tick,
  input wire logic dm_tx_src_data,
  input wire logic line_tx_data,
  input wire logic line_tx_tick,
  input wire logic line_tx_octet_mark,
  input wire logic dm_tx_data,
  input wire logic dm_tx_tick,
  input wire logic [1:0] mode_state
);
  logic [2:0] pos_q, pos_d;
  // Bit position seen from outside, cleared by reset like the design's
  always_comb pos_d = pos_q + 3'(line_tx_tick);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) pos_q <= 3'h0;
    else pos_q <= pos_d;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_mode_load: assert property (cfg_load |=> mode_state ==
    $past({timing_mode_select_high, timing_mode_select_low})) else $error("mode load");
  chk_loop_tick: assert property (mode_state == 2'h0 && line_rx_tick |=>
    line_tx_tick) else $error("loop tick");
  chk_int_gap: assert property (mode_state == 2'h1 && $past(mode_state) == 2'h1
    && line_tx_tick |=> !line_tx_tick ##1 (!line_tx_tick || $past(mode_state) != 2'h1))
    else $error("internal tick");
  chk_line_return: assert property (mode_state[1] && line_rx_tick |=>
    line_tx_tick && line_tx_data == $past(line_rx_data ^ line_rx_invert))
    else $error("line return");
  chk_rx_forward: assert property (mode_state != 2'h3 && line_rx_tick
    && !line_rx_invert |=> dm_tx_tick && dm_tx_data == $past(line_rx_data))
    else $error("rx forward");
  chk_dual_in: assert property (mode_state == 2'h3 && dm_rx_tick |=>
    dm_tx_tick && dm_tx_data == $past(dm_rx_data)) else $error("dual inward");
  chk_mark_pos: assert property ($rose(line_tx_octet_mark) |->
    line_tx_tick && pos_q == 3'h7) else $error("mark position");
  chk_mark_loop: assert property (mode_state[1] && $past(mode_state[1])
    && line_tx_tick |-> !line_tx_octet_mark) else $error("mark in loopback");
  cover property (mode_state == 2'h3 && dm_rx_tick);
  cover property ($rose(line_tx_octet_mark));
  cover property (mode_state == 2'h2 && line_rx_tick && line_rx_invert);
endmodule : gtl_timing_loopback_props
bind gtl_timing_loopback gtl_timing_loopback_props #(.BIT_DIV(BIT_DIV)) u_props (.*);

// *** dv/gtl_line_partner.sv ***
// Far-side line model: supplies recovered bit strobes and line data.
// Assumes strobes are sampled on core_clk rising edges.
`timescale 1ns/1ns
module gtl_line_partner (
  input wire logic core_clk,
  input wire logic en,
  input wire logic [7:0] per,
  output logic tick,
  output logic data
);
  logic [7:0] cnt_q = 8'h00;
  logic [15:0] pat_q = 16'hB4E1;
  initial tick = 1'h0;
  initial data = 1'h0;
  // Line side owns the timing in both loopbacks
  always @(posedge core_clk) begin
    tick <= en && cnt_q == 8'h00;
    cnt_q <= (cnt_q >= per - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    // Toggling between strobes so a stale bit never looks valid
    data <= (en && cnt_q == 8'h00) ? pat_q[15] : ~data;
    if (en && cnt_q == 8'h00) pat_q <= {pat_q[14:0], pat_q[15]};
  end
endmodule : gtl_line_partner

// *** dv/gtl_timing_loopback_test.sv ***
// Testbench: modes, timing sources, octet marker and loopbacks.
// Assumes the line partner model and BIT_DIV reduced to 4.
`timescale 1ns/1ns
module gtl_timing_loopback_test;
  logic clk = 0, rst = 1, oct = 1, lo = 0, hi = 0, ld = 0, inv = 0;
  logic dmr = 0, dmt = 0, src = 0, en = 0, ltd, ltt, mk, dtd, dtt, rtk, rdt;
  logic [1:0] ms;
  logic [7:0] per = 8'h06;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #50 clk = ~clk;
  gtl_line_partner far (.core_clk(clk), .en(en), .per(per), .tick(rtk), .data(rdt));
  gtl_timing_loopback #(.BIT_DIV(4)) dut (.core_clk(clk), .rst(rst),
    .octet_timing_select(oct), .timing_mode_select_low(lo),
    .timing_mode_select_high(hi), .cfg_load(ld), .line_rx_data(rdt),
    .line_rx_tick(rtk), .line_rx_invert(inv), .dm_rx_data(dmr), .dm_rx_tick(dmt),
    .dm_tx_src_data(src), .line_tx_data(ltd), .line_tx_tick(ltt),
    .line_tx_octet_mark(mk), .dm_tx_data(dtd), .dm_tx_tick(dtt), .mode_state(ms));
  task chk(string n, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  task end_of_test;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Run needs about 1400 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task set_mode(logic o, logic [1:0] m);
    @(posedge clk) {oct, hi, lo, ld} <= {o, m, 1'b1};
    @(posedge clk) ld <= 0;
    @(negedge clk) chk("mode", ms, m);
  endtask : set_mode
  task count(int n, output int t, output int k);
    t = 0;
    k = 0;
    repeat (n) @(negedge clk) begin
      t += ltt;
      k += ltt & mk;
    end
  endtask : count
  task t_loop;
    int t, k;
    count(480, t, k);
    chk("loop ticks", t, 80);
    chk("marks", k, 10);
  endtask : t_loop
  task t_internal;
    int t, k;
    set_mode(1, 2'h1);
    @(posedge clk) per <= 8'h02;
    count(400, t, k);
    chk("int ticks", t, 100);
  endtask : t_internal
  task t_b2b;
    int t, k;
    set_mode(0, 2'h1);
    count(400, t, k);
    chk("no marks", k, 0);
    // Source data is taken on the internal tick and sent on the line
    for (int i = 0; i < 4; i++) begin
      @(negedge clk iff ltt);
      @(posedge clk) src <= i[0];
      @(negedge clk iff ltt) chk("line data", ltd, i[0]);
    end
  endtask : t_b2b
  task t_remote;
    logic d;
    set_mode(1, 2'h2);
    @(posedge clk) {inv, src, per} <= {2'b11, 8'h06};
    repeat (8) begin
      @(posedge clk iff rtk) d = rdt;
      @(negedge clk) chk("remote", {ltt, ltd, mk}, {1'b1, ~d, 1'b0});
    end
  endtask : t_remote
  task t_dual;
    set_mode(1, 2'h3);
    @(posedge clk) inv <= 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) {dmt, dmr} <= {1'b1, i[0] ^ i[2]};
      @(posedge clk) dmt <= 0;
      @(negedge clk) chk("dual in", {dtt, dtd}, {1'b1, i[0] ^ i[2]});
    end
  endtask : t_dual
  initial begin
    repeat (12) @(posedge clk);
    {rst, en} <= 2'b01;
    @(negedge clk) chk("reset mode", ms, 2'h0);
    t_loop();
    t_internal();
    t_b2b();
    t_remote();
    t_dual();
    end_of_test();
  end
endmodule : gtl_timing_loopback_test
